// file: mqrps_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mqrps_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, push_valid;
    logic ras, aes, ren_n, ode_n, oe, vld_n, aeoe, go, sct, busy, err, timed, ren_s, vld_s;
    logic [7:0] paddr, rqa, cad, lines, ael;
    logic [31:0] pwdata, prdata, rdv, rng;
    logic [3:0] push_queue;
    logic [mqrps_pkg::DW-1:0] push_data, read_data, hv, lastw;
    logic [mqrps_pkg::DW-1:0] mq [16][$];
    logic [mqrps_pkg::DW-1:0] expw [$];
    int expc [$];
    int cur, cyc, miscompares, checked;
    logic [2:0] pos;
    logic [15:0] qf, qfe;

    mqrps_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .push_valid(push_valid),
        .push_queue(push_queue), .push_data(push_data), .queue_full(qf),
        .read_queue_address(rqa), .read_address_strobe(ras), .almost_empty_bus_strobe(aes),
        .read_enable_n(ren_n), .output_drive_en_n(ode_n), .chip_position_pins(pos),
        .read_data(read_data), .read_data_oe(oe), .word_valid_flag_n(vld_n),
        .almost_empty_sector_lines(lines), .almost_empty_oe(aeoe));
    mqrps_ctl ctl (.pclk(pclk), .presetn(presetn), .go(go), .sector(sct), .addr(cad),
        .read_queue_address(rqa), .read_address_strobe(ras),
        .almost_empty_bus_strobe(aes), .busy(busy));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // leaves push_valid high: the caller lowers it after the last fill
    task automatic fill(input logic [3:0] q, input int n);
        repeat (n) begin
            push_valid <= 1'b1;
            push_queue <= q;
            push_data <= mqrps_pkg::DW'(xs());
            @(posedge pclk);
        end
    endtask : fill

    task automatic sel(input logic [7:0] a, input logic s);
        while (busy === 1'b1) @(posedge pclk);
        go <= 1'b1;
        cad <= a;
        sct <= s;
        @(posedge pclk);
        go <= 1'b0;
    endtask : sel

    // reference: pops follow the selection one edge late, a word loads one edge after its pop
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (presetn === 1'b1) begin
            if (!ren_n && cur >= 0 && mq[cur].size() > 0) begin
                expw.push_back(mq[cur].pop_front());
                expc.push_back(cyc + 1);
            end
            if (ras) cur = (rqa[7:5] == pos && !rqa[4]) ? int'(rqa[3:0]) : -1;
            if (push_valid) mq[push_queue].push_back(push_data);
        end
        ren_s <= ren_n;
        vld_s <= vld_n;
    end

    always @(negedge pclk) begin
        if (presetn === 1'b1 && vld_n === 1'b0 && (ren_s === 1'b0 || vld_s === 1'b1)) begin
            if (expw.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                lastw = expw.pop_front();
                check(32'(read_data), 32'(lastw));
                if (timed) check(expc.pop_front(), cyc);
                else void'(expc.pop_front());
            end
        end
    end

    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, push_valid, go, sct, ren_n, ode_n, timed} = 10'h0;
        {paddr, pwdata, push_queue, push_data, cad, pos} = '0;
        rng = 32'hD6F5;
        {cur, cyc, miscompares, checked} = {-32'sd1, 96'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, mqrps_pkg::OFS_CTRL, 32'h0);
        check(rdv, 32'(mqrps_pkg::AE_LEVEL_RST));
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, mqrps_pkg::OFS_INT_MASK, 32'h1);
        fill(4'h1, 8);
        fill(4'h2, 3);
        fill(4'h3, 2);
        fill(4'h5, 8);
        push_valid <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            sel(s == 2 ? 8'hE0 : (s == 1 ? 8'h07 : 8'h00), 1'b1);
            repeat (4) @(posedge pclk);
            if (s < 2) begin
                for (int k = 0; k < 8; k++) begin
                    ael[k] = mq[8 * s + k].size() > int'(mqrps_pkg::AE_LEVEL_RST);
                end
                check(32'(lines), 32'(ael));
            end
            check(32'(aeoe), s < 2);
        end
        for (int k = 0; k < 16; k++) qfe[k] = mq[k].size() == int'(mqrps_pkg::DEPTH);
        check(32'(qf), 32'(qfe));
        timed = 1'b1;
        sel(8'h01, 1'b0);
        repeat (3) @(posedge pclk);
        sel(8'h02, 1'b0);
        sel(8'hA3, 1'b0);
        repeat (8) @(posedge pclk);
        check(32'(oe), 32'h0);
        sel(8'h03, 1'b0);
        repeat (3) @(posedge pclk);
        check(32'(oe), 32'h1);
        ode_n <= 1'b1;
        repeat (2) @(posedge pclk);
        check(32'(oe), 32'h0);
        sel(8'h05, 1'b0);
        repeat (3) @(posedge pclk);
        sel(8'h15, 1'b0);
        repeat (6) @(posedge pclk);
        check(32'(vld_n), 32'h1);
        check(32'(read_data), 32'(lastw));
        check(32'(irq), 32'h1);
        apb(1'b0, mqrps_pkg::OFS_INT_STAT, 32'h0);
        check(32'(rdv[mqrps_pkg::EV_EMPTY_SEL]), 32'h1);
        apb(1'b1, mqrps_pkg::OFS_INT_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        timed = 1'b0;
        // move this part to position 6 so a non-zero code must match
        pos <= 3'h6;
        fill(4'h4, 4);
        push_valid <= 1'b0;
        sel(8'hC4, 1'b0);
        do @(posedge pclk); while (vld_n !== 1'b0);
        ren_n <= 1'b1;
        @(posedge pclk);
        hv = read_data;
        repeat (4) @(posedge pclk);
        check(32'(read_data), 32'(hv));
        check(32'(vld_n), 32'h0);
        ren_n <= 1'b0;
        repeat (8) @(posedge pclk);
        check(expw.size(), 32'h0);
        results();
    end
endmodule : mqrps_bench
`default_nettype wire

// file: mqrps_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module mqrps_ctl (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset
    input wire logic go, // issue one strobe
    input wire logic sector, // sector strobe, not selection
    input wire logic [7:0] addr, // address to issue
    output logic [7:0] read_queue_address, // address bus
    output logic read_address_strobe, // selection strobe
    output logic almost_empty_bus_strobe, // sector strobe
    output logic busy // still spacing strobes
);
    logic [1:0] gap_q;
    logic take;
    assign take = go && gap_q == 2'h0;
    assign busy = go || gap_q != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 2'h0;
            read_queue_address <= 8'h00;
            read_address_strobe <= 1'b0;
            almost_empty_bus_strobe <= 1'b0;
        end else begin
            read_address_strobe <= take && !sector;
            almost_empty_bus_strobe <= take && sector;
            // released bus keeps changing so a stale address never looks valid
            read_queue_address <= take ? addr : ~read_queue_address;
            gap_q <= take ? 2'h3 : gap_q - {1'b0, gap_q != 2'h0};
        end
    end
endmodule : mqrps_ctl
`default_nettype wire

// file: mqrps_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mqrps_mem (
    input wire logic pclk, // clock
    input wire logic clk_en, // freezes the memory while low
    input wire logic we, // write strobe
    input wire logic [mqrps_pkg::AW-1:0] waddr, // write word address
    input wire logic [mqrps_pkg::DW-1:0] wdata, // write data
    input wire logic re, // read strobe
    input wire logic [mqrps_pkg::AW-1:0] raddr, // read word address
    output logic [mqrps_pkg::DW-1:0] rdata // registered read data
);
    logic [mqrps_pkg::DW-1:0] mem_q [2**mqrps_pkg::AW];

    // no reset on the array so it can map onto block ram
    always_ff @(posedge pclk) begin
        if (clk_en && we) begin
            mem_q[waddr] <= wdata;
        end
        if (clk_en && re) begin
            rdata <= mem_q[raddr];
        end
    end
endmodule : mqrps_mem
`default_nettype wire

// file: mqrps_pkg.sv
`default_nettype none
package mqrps_pkg;
    localparam int NQ = 16;
    localparam int QIW = 4;
    localparam int PW = 3;
    localparam int DW = 18;
    localparam int AW = QIW + PW;
    localparam int NEV = 3;
    localparam logic [3:0] DEPTH = 4'h8;
    localparam int NULL_BIT = 4;
    localparam int DEV_LSB = 5;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0C;
    localparam logic [7:0] OFS_LEVEL = 8'h10;
    localparam logic [7:0] OFS_FULL = 8'h14;
    // reset values
    localparam logic [3:0] AE_LEVEL_RST = 4'h2;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    // interrupt status bit positions
    localparam int EV_EMPTY_SEL = 0;
    localparam int EV_UNDERRUN = 1;
    localparam int EV_OVERFLOW = 2;
    // status register field positions
    localparam int ST_POS_LSB = 0;
    localparam int ST_SEL_LSB = 4;
    localparam int ST_NULL = 8;
    localparam int ST_HERE = 9;
    localparam int ST_STAGE = 10;
    localparam int ST_VALID_N = 11;
    localparam int ST_SECTOR = 12;
endpackage : mqrps_pkg
`default_nettype wire

// file: mqrps_top.sv
// Function
// RL1: strobe high at a clock edge takes the read queue address as new selection
// RL2: a selection persists; all later reads come from it until reselected
// RL3: controller spaces queue selections at least two clock cycles apart
// RL4: first word of a non-empty new queue reaches output two cycles later
// RL5: selecting edge and the next still read the previous queue
// RL6: drive enable only gates output drivers; output register loads regardless
// RL7: pipeline holds previous queue's last word and new queue's first word
// RL8: empty queue selected: two last reads from old queue, none from new
// RL9: no new word: output keeps last word, valid flag goes high
// RL10: eight-bit address; low four bits pick one of sixteen queues
// RL11: address bit 4 selects the idle queue, low bits ignored
// RL12: idle queue acts as empty queue, flushing the pipeline
// RL13: top three address bits must match position pins to act
// RL14: sector strobe: bit 0 picks queues 0-7 or 8-15 for flag lines
// RL15: one word can leave on every edge, even during selections
// RL16: queue advances only on read enable with data; else output holds; code also pops into an empty stage without read enable
`timescale 1ns/100ps
`default_nettype none
module mqrps_top (
    input wire logic pclk, // clock, read clock too
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state while low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic irq, // level interrupt
    input wire logic push_valid, // write a word into a queue
    input wire logic [mqrps_pkg::QIW-1:0] push_queue, // queue to write
    input wire logic [mqrps_pkg::DW-1:0] push_data, // word to write
    output logic [mqrps_pkg::NQ-1:0] queue_full, // per-queue full status
    input wire logic [7:0] read_queue_address, // read address bus
    input wire logic read_address_strobe, // take address as selection
    input wire logic almost_empty_bus_strobe, // take address as sector
    input wire logic read_enable_n, // read enable, active low
    input wire logic output_drive_en_n, // output drive enable, active low
    input wire logic [2:0] chip_position_pins, // static position code
    output logic [mqrps_pkg::DW-1:0] read_data, // output register
    output logic read_data_oe, // drive read_data
    output logic word_valid_flag_n, // output word invalid when high
    output logic [7:0] almost_empty_sector_lines, // active-low flags
    output logic almost_empty_oe // drive the flag lines
);
    logic [2:0] pos_s1_q, pos_s2_q, pos_s3_q, pos_q;
    logic [mqrps_pkg::QIW-1:0] sel_q;
    logic sel_null_q, sel_here_q, stg_v_q, sector_q, sector_here_q;
    logic [3:0] ae_level_q;
    logic [mqrps_pkg::NEV-1:0] int_stat_q, int_mask_q;
    logic [3:0] cnt_q [mqrps_pkg::NQ];
    logic [mqrps_pkg::PW-1:0] wp_q [mqrps_pkg::NQ];
    logic [mqrps_pkg::PW-1:0] rp_q [mqrps_pkg::NQ];
    logic [mqrps_pkg::NQ-1:0] full_w, ae_w;
    logic [mqrps_pkg::DW-1:0] mem_rdata;
    logic [31:0] rd_d;

    // position pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_s1_q <= 3'h0;
            pos_s2_q <= 3'h0;
            pos_s3_q <= 3'h0;
            pos_q <= 3'h0;
        end else if (clk_en) begin
            pos_s1_q <= chip_position_pins;
            pos_s2_q <= pos_s1_q;
            pos_s3_q <= pos_s2_q;
            if (pos_s2_q == pos_s3_q) begin
                pos_q <= pos_s3_q;
            end
        end
    end

    // address decode
    wire logic dev_hit = read_queue_address[7:mqrps_pkg::DEV_LSB] == pos_q; // RL13
    wire logic [mqrps_pkg::QIW-1:0] addr_queue = read_queue_address[mqrps_pkg::QIW-1:0]; // RL10
    wire logic addr_null = read_queue_address[mqrps_pkg::NULL_BIT]; // RL11
    wire logic sel_take = read_address_strobe; // RL1
    wire logic sector_take = almost_empty_bus_strobe & ~read_address_strobe; // RL14
    wire logic new_empty = addr_null | (cnt_q[addr_queue] == 4'h0);

    // read datapath
    wire logic sel_live = sel_here_q & ~sel_null_q; // RL12
    wire logic q_has = cnt_q[sel_q] != 4'h0;
    // a stage word falls through into an invalid output register without read enable
    wire logic advance = stg_v_q & (~read_enable_n | word_valid_flag_n); // RL16
    wire logic pop = sel_live & q_has & (~stg_v_q | advance); // RL15
    wire logic push_ok = push_valid & ~full_w[push_queue];
    wire logic [mqrps_pkg::AW-1:0] waddr = {push_queue, wp_q[push_queue]};
    wire logic [mqrps_pkg::AW-1:0] raddr = {sel_q, rp_q[sel_q]};

    // interrupt events
    wire logic [mqrps_pkg::NEV-1:0] ev;
    assign ev[mqrps_pkg::EV_EMPTY_SEL] = sel_take & dev_hit & new_empty;
    assign ev[mqrps_pkg::EV_UNDERRUN] = sel_here_q & ~read_enable_n & ~advance;
    assign ev[mqrps_pkg::EV_OVERFLOW] = push_valid & full_w[push_queue];

    genvar g;
    generate
        for (g = 0; g < mqrps_pkg::NQ; g++) begin : g_queue
            wire logic push_g = push_ok & (push_queue == mqrps_pkg::QIW'(g));
            wire logic pop_g = pop & (sel_q == mqrps_pkg::QIW'(g));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q[g] <= 4'h0;
                    wp_q[g] <= 3'h0;
                    rp_q[g] <= 3'h0;
                end else if (clk_en) begin
                    if (push_g) begin
                        wp_q[g] <= wp_q[g] + 3'h1;
                    end
                    if (pop_g) begin
                        rp_q[g] <= rp_q[g] + 3'h1;
                    end
                    if (push_g && !pop_g) begin
                        cnt_q[g] <= cnt_q[g] + 4'h1;
                    end else if (pop_g && !push_g) begin
                        cnt_q[g] <= cnt_q[g] - 4'h1;
                    end
                end
            end
            assign full_w[g] = cnt_q[g] == mqrps_pkg::DEPTH;
            assign ae_w[g] = cnt_q[g] <= ae_level_q;
        end
    endgenerate

    mqrps_mem u_mem (
        .pclk(pclk),
        .clk_en(clk_en),
        .we(push_ok),
        .waddr(waddr),
        .wdata(push_data),
        .re(pop),
        .raddr(raddr),
        .rdata(mem_rdata)
    );

    // selection: pops use the new queue from the edge after the selecting one,
    // so the selecting edge still pops the old queue into the stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 4'h0;
            sel_null_q <= 1'b1;
            sel_here_q <= 1'b0;
        end else if (clk_en && sel_take) begin
            sel_here_q <= dev_hit; // RL13
            if (dev_hit) begin
                sel_q <= addr_queue; // RL1 RL2
                sel_null_q <= addr_null; // RL11
            end
        end
    end

    // stage word plus output register form the two-deep pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_v_q <= 1'b0;
            read_data <= '0;
            word_valid_flag_n <= 1'b1;
        end else if (clk_en) begin
            if (pop) begin
                stg_v_q <= 1'b1; // RL7
            end else if (advance) begin
                stg_v_q <= 1'b0;
            end
            if (advance) begin
                read_data <= mem_rdata; // RL6 RL4 RL5
                word_valid_flag_n <= 1'b0;
            end else if (!read_enable_n) begin
                word_valid_flag_n <= 1'b1; // RL9 RL8
            end
        end
    end

    // pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data_oe <= 1'b0;
            sector_q <= 1'b0;
            sector_here_q <= 1'b0;
            almost_empty_sector_lines <= 8'hFF;
            almost_empty_oe <= 1'b0;
            queue_full <= '0;
        end else if (clk_en) begin
            read_data_oe <= ~output_drive_en_n & sel_here_q; // RL6
            if (sector_take) begin
                sector_here_q <= dev_hit; // RL14
                sector_q <= read_queue_address[0]; // RL14
            end
            almost_empty_sector_lines <= sector_q ? ~ae_w[15:8] : ~ae_w[7:0];
            almost_empty_oe <= sector_here_q;
            queue_full <= full_w;
        end
    end

    // apb slave: answers in the second access cycle
    wire logic acc = psel & penable & ~pready;
    // write lands on the completing edge, where the master sees pready
    wire logic wr = psel & penable & pready & pwrite;
    wire logic hit_ctrl = paddr == mqrps_pkg::OFS_CTRL;
    wire logic hit_stat = paddr == mqrps_pkg::OFS_STATUS;
    wire logic hit_int = paddr == mqrps_pkg::OFS_INT_STAT;
    wire logic hit_mask = paddr == mqrps_pkg::OFS_INT_MASK;
    wire logic hit_lvl = paddr == mqrps_pkg::OFS_LEVEL;
    wire logic hit_full = paddr == mqrps_pkg::OFS_FULL;
    wire logic hit_any = hit_ctrl | hit_stat | hit_int | hit_mask | hit_lvl | hit_full;
    wire logic [mqrps_pkg::NEV-1:0] w1c = (wr & hit_int) ? pwdata[2:0] : 3'h0;
    wire logic [mqrps_pkg::NEV-1:0] int_stat_d = (int_stat_q & ~w1c) | ev;

    always_comb begin
        rd_d = 32'h0;
        if (hit_ctrl) begin
            rd_d[3:0] = ae_level_q;
        end else if (hit_stat) begin
            rd_d[mqrps_pkg::ST_POS_LSB +: 3] = pos_q;
            rd_d[mqrps_pkg::ST_SEL_LSB +: 4] = sel_q;
            rd_d[mqrps_pkg::ST_NULL] = sel_null_q;
            rd_d[mqrps_pkg::ST_HERE] = sel_here_q;
            rd_d[mqrps_pkg::ST_STAGE] = stg_v_q;
            rd_d[mqrps_pkg::ST_VALID_N] = word_valid_flag_n;
            rd_d[mqrps_pkg::ST_SECTOR] = sector_q;
        end else if (hit_int) begin
            rd_d[2:0] = int_stat_q;
        end else if (hit_mask) begin
            rd_d[2:0] = int_mask_q;
        end else if (hit_lvl) begin
            rd_d[3:0] = cnt_q[sel_q];
        end else if (hit_full) begin
            rd_d[15:0] = full_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clk_en) begin
            pready <= acc;
            pslverr <= acc & ~hit_any;
            if (acc && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // set beats clear: int_stat_d ors the events in after the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_level_q <= mqrps_pkg::AE_LEVEL_RST;
            int_mask_q <= mqrps_pkg::INT_MASK_RST;
            int_stat_q <= 3'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (wr && hit_ctrl) begin
                ae_level_q <= pwdata[3:0];
            end
            if (wr && hit_mask) begin
                int_mask_q <= pwdata[2:0];
            end
            int_stat_q <= int_stat_d;
            irq <= |(int_stat_d & int_mask_q);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_sel_capture: assert property ( // RL1
        clk_en && sel_take && dev_hit && !addr_null
        |=> sel_q == $past(addr_queue) && !sel_null_q && sel_here_q)
        else $error("selection not captured");

    chk_sel_persist: assert property ( // RL2
        !sel_take |=> $stable(sel_q) && $stable(sel_here_q))
        else $error("selection changed without strobe");

    chk_dev_other: assert property ( // RL13
        clk_en && sel_take && !dev_hit |=> !sel_here_q ##1 !read_data_oe || !clk_en)
        else $error("foreign selection not ignored");

    chk_idle_nopop: assert property ( // RL12
        sel_null_q || !sel_here_q |-> !pop)
        else $error("idle queue popped");

    chk_pop_data: assert property ( // RL16
        pop |-> cnt_q[sel_q] != 4'h0)
        else $error("pop from empty queue");

    chk_out_hold: assert property ( // RL9
        clk_en && !advance |=> $stable(read_data))
        else $error("output register changed without a word");

    chk_valid_flag: assert property ( // RL9
        clk_en && !read_enable_n && !stg_v_q |=> word_valid_flag_n)
        else $error("valid flag low with no word");

    chk_load_free: assert property ( // RL6
        clk_en && pop ##1 clk_en && advance |=> read_data == $past(mem_rdata))
        else $error("stage word not loaded");

    chk_new_two: assert property ( // RL4
        clk_en && sel_take && dev_hit && !new_empty && !stg_v_q && !read_enable_n
        && addr_queue != sel_q ##1 clk_en && !sel_take ##1 clk_en |=> !word_valid_flag_n)
        else $error("new queue word late");

    chk_sector: assert property ( // RL14
        clk_en && sector_take |=> sector_q == $past(read_queue_address[0]))
        else $error("sector not captured");

    // switch sequences below lean on the controller keeping selections at least four cycles apart
    chk_old_queue: assert property ( // RL5
        clk_en && sel_take && sel_live && q_has && !stg_v_q |-> pop)
        else $error("selecting edge skipped the old queue");

    chk_null_select: assert property ( // RL11
        clk_en && sel_take && dev_hit && addr_null |=> sel_null_q && sel_here_q)
        else $error("idle queue not selected");

    chk_switch_pair: assert property ( // RL7
        clk_en && sel_take && dev_hit && !new_empty && addr_queue != sel_q
        ##1 clk_en && !read_enable_n && stg_v_q |-> advance && pop)
        else $error("old and new word not back to back");

    chk_empty_stop: assert property ( // RL8
        clk_en && sel_take && dev_hit && new_empty && !push_valid
        ##1 clk_en && !sel_take && !push_valid ##1 clk_en |-> !pop)
        else $error("empty queue read after selection");

    chk_sector_owner: assert property ( // RL14
        clk_en && sector_take ##1 clk_en && !sector_take
        |=> almost_empty_oe == $past(dev_hit, 2))
        else $error("flag line owner wrong");

    cov_switch_busy: cover property (clk_en && sel_take && advance ##1 advance ##1 advance);
    cov_null_flush: cover property (clk_en && sel_take && addr_null ##[1:4] word_valid_flag_n);
    cov_irq: cover property (irq ##1 !irq);
    cov_held_word: cover property (!word_valid_flag_n && read_enable_n ##1 !word_valid_flag_n);
endmodule : mqrps_top
`default_nettype wire
